// file: src/dbr_bus_release.sv
// Bus-release, reset-configuration, parity and cache-diagnostic logic.
// Assumes core drive values arrive on clk_sys; stall request and irq lines are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "dbr_cfg.svh"
// Overview of operation
// - Stall request stalls core, floats sync bus
// - Float address, data, tag, cache controls, enables
// - Hand over bus within few cycles
// - No asynchronous memory space arbitration here
// - Sample irq lines in last four reset cycles
// - Line 2: data size, parity, valid output
// - Line 3: instr size, partial store, control-low
// - Line 4: coprocessor lock-loop in all slots
// - Line 5: byte order X, tri-state Y
// - Swap exchanges instruction and data banks
// - Isolated caches report hit unless a parity error forces miss
// - Parity checked; error flags and forces miss
// - Parity error output held until software clears
module dbr_bus_release #(
  parameter int HANDOFF_MAX = `DBR_HANDOFF_MAX   // Worst-case cycles to hand over
) (
  // Clock, reset, enable
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  // External master and reset window pins
  input  wire logic                     bus_release_req,
  input  wire logic                     reset_win,
  input  wire logic [5:0]               irq_line,
  // Core side
  input  wire dbr_pkg::dbr_bus_t        core_bus,
  input  wire logic                     core_cycle_busy,
  input  wire logic                     sync_access,
  input  wire logic                     tag_match,
  input  wire logic [`DBR_DATA_W-1:0]   data_in,
  input  wire logic [`DBR_PAR_W-1:0]    parity_in,
  input  wire logic                     swap_caches,
  input  wire logic                     isolate_caches,
  input  wire logic                     parity_flag_clear,
  // Core control answers
  output logic                          core_stall,
  output logic                          cache_hit,
  output logic                          cache_miss_cycle,
  output logic                          parity_err_n,
  output dbr_pkg::dbr_mode_t            mode,
  output logic                          reserved_fault,
  // Synchronous bus pins
  output dbr_pkg::dbr_bus_t             bus_out,
  output logic                          bus_oe
);
  import dbr_pkg::*;
  logic [1:0]  req_sync_reg;              // Stall request synchroniser
  logic [5:0]  irq_s1_reg, irq_s2_reg;    // Irq line synchroniser
  logic        win_s1_reg, win_s2_reg;    // Reset window synchroniser
  dbr_state_t  state_reg, state_next;     // Handover state
  logic [1:0]  wait_reg, wait_next;       // Cycles spent draining
  logic        stall_reg, stall_next;
  logic        oe_reg, oe_next;
  dbr_bus_t    bus_reg, bus_next;
  logic        hit_reg, hit_next;
  logic        miss_reg, miss_next;
  logic        perr_reg, perr_next;       // Sticky parity error flag
  logic        par_bad;
  logic        req;
  dbr_mode_t   mode_w;
  logic        rsv_w;

  // Two flops on every pin input
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      req_sync_reg <= 2'b00;
      irq_s1_reg   <= 6'h3F;
      irq_s2_reg   <= 6'h3F;
      win_s1_reg   <= 1'b0;
      win_s2_reg   <= 1'b0;
    end else if (clk_en) begin
      req_sync_reg <= {req_sync_reg[0], bus_release_req};
      irq_s1_reg   <= irq_line;
      irq_s2_reg   <= irq_s1_reg;
      win_s1_reg   <= reset_win;
      win_s2_reg   <= win_s1_reg;
    end
  end
  assign req = req_sync_reg[1];

  // Mode options sampled at the end of reset
  dbr_mode_sampler u_sampler (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .clk_en         (clk_en),
    .reset_win      (win_s2_reg),
    .irq_sync       (irq_s2_reg),
    .mode           (mode_w),
    .reserved_fault (rsv_w)
  );

  // Byte-wise even parity over the data field
  always_comb begin
    par_bad = 1'b0;
    for (int i = 0; i < `DBR_PAR_W; i++) begin
      if ((^data_in[i*8 +: 8]) != parity_in[i]) par_bad = 1'b1;
    end
  end

  // Handover, bus drive, hit and parity decisions
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    stall_next = stall_reg;
    oe_next    = oe_reg;
    bus_next   = core_bus;
    hit_next   = 1'b0;
    miss_next  = 1'b0;
    perr_next  = perr_reg;
    // Only the synchronous bus is handed over; async space is left to buffers
    case (state_reg)
      DBR_OWN: begin
        oe_next = 1'b1;
        if (req) begin
          stall_next = 1'b1;
          wait_next  = 2'd0;
          state_next = DBR_DRAIN;
        end
      end
      DBR_DRAIN: begin
        // Let a running bus cycle finish, but never past the bound
        wait_next = wait_reg + 2'd1;
        if (!core_cycle_busy || (32'(wait_reg) + 32'd1 >= HANDOFF_MAX)) begin
          oe_next    = 1'b0;
          state_next = DBR_RELEASED;
        end
      end
      DBR_RELEASED: begin
        if (!req) begin
          oe_next    = 1'b1;
          stall_next = 1'b0;
          state_next = DBR_OWN;
        end
      end
      default: state_next = DBR_OWN;
    endcase
    // Bank roles swapped: instruction strobes drive data bank and back
    if (mode_w.valid_out_sel == 1'b0) bus_next.valid = 1'b0;
    if (swap_caches) begin
      bus_next.icache_read_n  = core_bus.dcache_read_n;
      bus_next.icache_write_n = core_bus.dcache_write_n;
      bus_next.dcache_read_n  = core_bus.icache_read_n;
      bus_next.dcache_write_n = core_bus.icache_write_n;
    end
    bus_next.data_oe = core_bus.data_oe && oe_next;
    if (sync_access && !stall_reg) begin
      if (mode_w.parity_en && par_bad) begin
        miss_next = 1'b1;
      end else begin
        hit_next  = isolate_caches || tag_match;
        miss_next = !(isolate_caches || tag_match);
      end
    end
    // Set beats clear in the same cycle
    if (parity_flag_clear) perr_next = 1'b0;
    if (sync_access && !stall_reg && mode_w.parity_en && par_bad) perr_next = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= DBR_OWN;
      wait_reg  <= 2'd0;
      stall_reg <= 1'b0;
      oe_reg    <= 1'b1;
      bus_reg   <= '1;
      hit_reg   <= 1'b0;
      miss_reg  <= 1'b0;
      perr_reg  <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      stall_reg <= stall_next;
      oe_reg    <= oe_next;
      bus_reg   <= bus_next;
      hit_reg   <= hit_next;
      miss_reg  <= miss_next;
      perr_reg  <= perr_next;
    end
  end

  // The sampler's outputs are registered inside it
  assign mode             = mode_w;
  assign reserved_fault   = rsv_w;
  assign core_stall       = stall_reg;
  assign cache_hit        = hit_reg;
  assign cache_miss_cycle = miss_reg;
  assign parity_err_n     = !perr_reg;
  assign bus_out          = bus_reg;
  assign bus_oe           = oe_reg;

  // Assertions
  sequence s_req_seen;
    req && state_reg == DBR_OWN && clk_en;
  endsequence
  property p_stall_on_req;
    @(posedge clk_sys) disable iff (reset) s_req_seen |=> core_stall;
  endproperty
  a_stall_on_req: assert property (p_stall_on_req) else $error("no stall after request");
  property p_float_when_released;
    @(posedge clk_sys) disable iff (reset) state_reg == DBR_RELEASED |-> !bus_oe && core_stall;
  endproperty
  a_float_when_released: assert property (p_float_when_released) else $error("bus driven while released");
  property p_handoff_bound;
    @(posedge clk_sys) disable iff (reset)
      (s_req_seen ##1 (clk_en && req) [*4]) |-> !bus_oe;
  endproperty
  a_handoff_bound: assert property (p_handoff_bound) else $error("bus not released in time");
  property p_reclaim;
    @(posedge clk_sys) disable iff (reset)
      (state_reg == DBR_RELEASED && !req && clk_en) |=> bus_oe && !core_stall;
  endproperty
  a_reclaim: assert property (p_reclaim) else $error("bus not reclaimed");
  property p_isolate_hit;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && sync_access && !stall_reg && isolate_caches && !(mode_w.parity_en && par_bad)) |=> cache_hit;
  endproperty
  a_isolate_hit: assert property (p_isolate_hit) else $error("isolated access missed");
  property p_parity_err;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && sync_access && !stall_reg && mode_w.parity_en && par_bad) |=> !parity_err_n && cache_miss_cycle;
  endproperty
  a_parity_err: assert property (p_parity_err) else $error("parity error not reported");
  property p_parity_sticky;
    @(posedge clk_sys) disable iff (reset)
      (!parity_err_n && !parity_flag_clear) |=> !parity_err_n;
  endproperty
  a_parity_sticky: assert property (p_parity_sticky) else $error("parity error dropped early");
  property p_swap;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && swap_caches) |=> bus_out.dcache_read_n == $past(core_bus.icache_read_n);
  endproperty
  a_swap: assert property (p_swap) else $error("banks not swapped");
endmodule
`default_nettype wire

// file: src/dbr_cfg.svh
// Constants of the bus-release and reset-configuration block.
// Assumes inclusion by the package, the design modules and the testbench.
`ifndef DBR_CFG_SVH
`define DBR_CFG_SVH
`define DBR_ADDR_W      16
`define DBR_DATA_W      32
`define DBR_TAG_W       20
`define DBR_PAR_W       4
`define DBR_RST_SLOTS   4
`define DBR_SLOT_W      0
`define DBR_SLOT_X      1
`define DBR_SLOT_Y      2
`define DBR_SLOT_Z      3
`define DBR_HANDOFF_MAX 3
`define DBR_CFG_RESET   11'h000
`endif

// file: src/dbr_pkg.sv
// Types shared by the bus-release block and its configuration sampler.
// Assumes dbr_cfg.svh sits on the include path.
`include "dbr_cfg.svh"
package dbr_pkg;
  // Mode options caught during the last four reset cycles
  typedef struct packed {
    logic [1:0] data_refill_size;
    logic       parity_en;
    logic       valid_out_sel;
    logic [1:0] instr_refill_size;
    logic       partial_store_sel;
    logic       control_low_sel;
    logic       coproc_lock_loop_sel;
    logic       byte_order_sel;
    logic       float_outputs_sel;
  } dbr_mode_t;
  // Core-side synchronous-bus drive values
  typedef struct packed {
    logic [`DBR_ADDR_W-1:0] addr;
    logic [`DBR_DATA_W-1:0] data;
    logic [`DBR_TAG_W-1:0]  tag;
    logic                   data_oe;
    logic                   icache_read_n;
    logic                   icache_write_n;
    logic                   icache_clock;
    logic                   dcache_read_n;
    logic                   dcache_write_n;
    logic                   dcache_clock;
    logic                   read_buffer_xcvr_en;
    logic                   valid;
  } dbr_bus_t;
  // Handover state machine
  typedef enum logic [1:0] {DBR_OWN, DBR_DRAIN, DBR_RELEASED} dbr_state_t;
endpackage

// file: src/dbr_mode_sampler.sv
// Reset-window sampler of the mode options carried on the interrupt lines.
// Assumes irq lines already synchronised; reset_win marks the last four reset cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dbr_cfg.svh"
module dbr_mode_sampler (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Sampling window and lines
  input  wire logic              reset_win,
  input  wire logic [5:0]        irq_sync,
  // Latched options
  output dbr_pkg::dbr_mode_t     mode,
  output logic                   reserved_fault
);
  import dbr_pkg::*;
  logic [1:0]  slot_reg, slot_next;        // Slot counter W..Z
  logic        win_d_reg, win_d_next;      // Window seen last cycle
  dbr_mode_t   shadow_reg, shadow_next;    // Options gathered inside window
  dbr_mode_t   mode_reg, mode_next;        // Options held until next reset
  logic        rsv_reg, rsv_next;          // A reserved slot was driven low

  // Gather per slot, commit when the window closes
  always_comb begin
    slot_next   = slot_reg;
    win_d_next  = reset_win;
    shadow_next = shadow_reg;
    mode_next   = mode_reg;
    rsv_next    = rsv_reg;
    if (reset_win) begin
      slot_next = (!win_d_reg) ? 2'd1 : slot_reg + 2'd1;
      // Reserved slots should read high; flag it otherwise
      if (!irq_sync[0] || !irq_sync[1]) rsv_next = 1'b1;
      case (win_d_reg ? slot_reg : 2'd0)
        2'(`DBR_SLOT_W): begin
          shadow_next.data_refill_size[0]  = irq_sync[2];
          shadow_next.instr_refill_size[0] = irq_sync[3];
          if (!irq_sync[5]) rsv_next = 1'b1;
        end
        2'(`DBR_SLOT_X): begin
          shadow_next.data_refill_size[1]  = irq_sync[2];
          shadow_next.instr_refill_size[1] = irq_sync[3];
          shadow_next.byte_order_sel       = irq_sync[5];
        end
        2'(`DBR_SLOT_Y): begin
          shadow_next.parity_en         = irq_sync[2];
          shadow_next.partial_store_sel = irq_sync[3];
          shadow_next.float_outputs_sel = irq_sync[5];
        end
        default: begin
          shadow_next.valid_out_sel   = irq_sync[2];
          shadow_next.control_low_sel = irq_sync[3];
          if (!irq_sync[5]) rsv_next = 1'b1;
        end
      endcase
      // Same option in every slot; the last one wins
      shadow_next.coproc_lock_loop_sel = irq_sync[4];
    end else if (win_d_reg) begin
      mode_next = shadow_reg;
    end
  end

  // Registers; the held options change only at window close
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slot_reg   <= 2'd0;
      win_d_reg  <= 1'b0;
      shadow_reg <= dbr_mode_t'(`DBR_CFG_RESET);
      mode_reg   <= dbr_mode_t'(`DBR_CFG_RESET);
      rsv_reg    <= 1'b0;
    end else if (clk_en) begin
      slot_reg   <= slot_next;
      win_d_reg  <= win_d_next;
      shadow_reg <= shadow_next;
      mode_reg   <= mode_next;
      rsv_reg    <= rsv_next;
    end
  end

  assign mode           = mode_reg;
  assign reserved_fault = rsv_reg;

  // Held options stay put outside the window edge
  property p_mode_hold;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && !win_d_reg) |=> $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside window close");
endmodule
`default_nettype wire

// file: verif/dbr_dma_master.sv
// External bus master model that borrows the synchronous bus through the release request.
// Assumes the bench pulses start for one cycle and keeps hold_cycles steady meanwhile.
`timescale 1ns/1ps
`default_nettype none
module dbr_dma_master (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Bench control
  input  wire logic       start,
  input  wire logic [7:0] hold_cycles,
  output var  logic       done,
  // Device side
  input  wire logic       bus_oe,
  output var  logic       bus_release_req
);
  int i;  // Bounded wait counter
  initial begin
    bus_release_req = 1'b0;
    done            = 1'b0;
  end
  // One borrow: request, wait for the float, hold, then give the bus back
  always begin
    @(posedge clk_sys iff (start && !reset));
    #1 bus_release_req = 1'b1;
    // Bounded so a dead device cannot hang the model
    for (i = 0; i < 20 && bus_oe !== 1'b0; i++) begin
      @(posedge clk_sys);
    end
    repeat (hold_cycles) @(posedge clk_sys);
    // Drop after the hold, once the float is seen or the 20-cycle wait runs out
    #1 bus_release_req = 1'b0;
    for (i = 0; i < 20 && bus_oe !== 1'b1; i++) begin
      @(posedge clk_sys);
    end
    #1 done = 1'b1;
    @(posedge clk_sys);
    #1 done = 1'b0;
  end
endmodule
`default_nettype wire

// file: verif/dbr_bus_release_tb.sv
// Self-checking bench for the bus-release and reset-option block.
// Assumes the design package and header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dbr_cfg.svh"
module dbr_bus_release_tb;
  import dbr_pkg::*;
  // Access row: stimulus beside expected answers
  typedef struct packed {
    logic [31:0] data; logic bad; logic tm; logic iso; logic hit; logic miss; logic perr_n;
  } dbr_row_t;
  logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, reset_win = 1'b0;
  logic [5:0] irq_line = 6'h3F;
  dbr_bus_t   core_bus = '0, bus_out;
  logic core_cycle_busy = 1'b0, sync_access = 1'b0, tag_match = 1'b0, swap_caches = 1'b0;
  logic isolate_caches = 1'b0, parity_flag_clear = 1'b0, core_stall, cache_hit, cache_miss_cycle;
  logic parity_err_n, reserved_fault, bus_oe, bus_release_req, start = 1'b0, done, seen, seen_miss;
  logic [31:0] data_in = 32'h0;
  logic [3:0]  parity_in = 4'h0;
  logic [7:0]  hold = 8'h08;
  dbr_mode_t   mode, exp_mode;
  int n_mismatch = 0, check_count = 0, n, k;
  // Parity errors sit last so the sticky output is only expected low at the end
  dbr_row_t rows [4] = '{
    '{32'h12345678, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
    '{32'hA5A5F00F, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
    '{32'h0000FF01, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
    '{32'hDEADBEEF, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0}};
  always #5 clk_sys = ~clk_sys;
  dbr_bus_release dbr_bus_release_inst (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .bus_release_req(bus_release_req), .reset_win(reset_win), .irq_line(irq_line),
    .core_bus(core_bus), .core_cycle_busy(core_cycle_busy), .sync_access(sync_access),
    .tag_match(tag_match), .data_in(data_in), .parity_in(parity_in), .swap_caches(swap_caches),
    .isolate_caches(isolate_caches), .parity_flag_clear(parity_flag_clear), .core_stall(core_stall),
    .cache_hit(cache_hit), .cache_miss_cycle(cache_miss_cycle), .parity_err_n(parity_err_n),
    .mode(mode), .reserved_fault(reserved_fault), .bus_out(bus_out), .bus_oe(bus_oe));
  dbr_dma_master dbr_dma_master_inst (.clk_sys(clk_sys), .reset(reset), .start(start),
    .hold_cycles(hold), .done(done), .bus_oe(bus_oe), .bus_release_req(bus_release_req));
  // Compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset, then one option window; slot W sits in bits 5:0
  task automatic run_window(input logic [23:0] slots);
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    // Reset state: bus driven, no stall, no parity error, options cleared
    check(64'({bus_oe, core_stall, parity_err_n, reserved_fault, mode}), 64'h5000);
    @(posedge clk_sys);
    for (int s = 0; s < 4; s++) begin
      #1 irq_line = slots[s*6 +: 6];
      reset_win = 1'b1;
      @(posedge clk_sys);
    end
    #1 reset_win = 1'b0;
    irq_line = 6'h3F;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  // Strobe one access; the answer pulse stands for the cycle after the sampling edge
  task automatic access(input logic [31:0] d, input logic bad, input logic tm);
    data_in = d;
    for (int b = 0; b < 4; b++) parity_in[b] = (^d[b*8 +: 8]) ^ (bad && b == 0);
    tag_match = tm;
    sync_access = 1'b1;
    @(posedge clk_sys);
    #1 sync_access = 1'b0;
    seen = cache_hit;
    seen_miss = cache_miss_cycle;
    @(posedge clk_sys);
    #1;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    // Line 2 = 1,0,1,1; line 3 = 0,1,1,0; line 4 high; line 5 = 1,1,0,1
    run_window({6'h37, 6'h1F, 6'h3B, 6'h37});
    exp_mode = '{data_refill_size: 2'h1, parity_en: 1'b1, valid_out_sel: 1'b1,
      instr_refill_size: 2'h2, partial_store_sel: 1'b1, control_low_sel: 1'b0,
      coproc_lock_loop_sel: 1'b1, byte_order_sel: 1'b1, float_outputs_sel: 1'b0};
    check(64'(mode), 64'(exp_mode));
    check(64'(reserved_fault), 64'h0);
    irq_line = 6'h00;
    for (k = 0; k < 4; k++) begin
      isolate_caches = rows[k].iso;
      access(rows[k].data, rows[k].bad, rows[k].tm);
      check(64'(seen), 64'(rows[k].hit));
      check(64'(seen_miss), 64'(rows[k].miss));
      check(64'(parity_err_n), 64'(rows[k].perr_n));
    end
    repeat (5) @(posedge clk_sys);
    #1 check(64'(parity_err_n), 64'h0);
    parity_flag_clear = 1'b1;
    @(posedge clk_sys);
    #1 parity_flag_clear = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check(64'(parity_err_n), 64'h1);
    // Swap exchanges the bank strobes, and back again
    core_bus.icache_read_n = 1'b0;
    core_bus.dcache_read_n = 1'b1;
    core_bus.data_oe = 1'b1;
    core_bus.valid = 1'b1;
    for (k = 0; k < 2; k++) begin
      swap_caches = !k[0];
      repeat (3) @(posedge clk_sys);
      #1 check(64'(bus_out.icache_read_n), 64'(!k[0]));
      check(64'(bus_out.dcache_read_n), 64'(k[0]));
    end
    // Valid output selected in slot Z, so the core's valid passes
    check(64'(bus_out.valid), 64'h1);
    // Release with the core idle, then with a cycle in progress
    for (k = 0; k < 2; k++) begin
      core_cycle_busy = k[0];
      start = 1'b1;
      @(posedge clk_sys);
      #1 start = 1'b0;
      // Count edges from the pin rising until the float is seen, sampled off the edge
      for (n = 0; n < 20 && bus_oe !== 1'b0; n++) begin
        @(posedge clk_sys);
        #1;
      end
      check(64'(n), k[0] ? 64'(3 + `DBR_HANDOFF_MAX) : 64'h4);
      check(64'(core_stall), 64'h1);
      check(64'(bus_out.data_oe), 64'h0);
      access(32'h00000000, 1'b0, 1'b1);
      check(64'(seen | seen_miss), 64'h0);
      for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge clk_sys);
      #1 check(64'(bus_oe), 64'h1);
      check(64'(core_stall), 64'h0);
      check(64'(bus_out.data_oe), 64'h1);
      core_cycle_busy = 1'b0;
    end
    check(64'(mode), 64'(exp_mode));
    // Line 0 low in slot W must be flagged
    run_window({6'h3F, 6'h3F, 6'h3F, 6'h3E});
    check(64'(reserved_fault), 64'h1);
    check(64'(mode), 64'h7FF);
    summarize();
  end
endmodule
`default_nettype wire
